// [hw/acce_exec.sv]
// Execution slice for assertions, calls, clz, constant loads and classify.
// How it works
// RULE1: Signed greater, less-equal and less assertions continue when true and trap otherwise.
// RULE2: Unsigned forms of those assertions compare operands as unsigned values.
// RULE3: The not-equal assertion traps when both source operands are equal.
// RULE4: Operand select 0 takes the second source from a register, 1 zero-extends bits 7..0.
// RULE5: In user mode a vector 0..63 gives a protection trap in place of the assertion trap.
// RULE6: The direct call links the current address plus 8 and runs one delay slot.
// RULE7: The direct call target is the 16-bit word offset, relative or absolute by bit 24.
// RULE8: The indirect call links likewise and jumps to the second source register.
// RULE9: Classify traps with pointers A and C at source and dest and pointer B at the format.
// RULE10: The class result clears bits 31..6, sets bit 5 for negatives, and codes bits 4..0.
// RULE11: Zero, infinity, signalling and quiet NaN codes follow the fixed class table.
// RULE12: Format 01 is single, 10 is double, 00 and 11 are reserved.
// RULE13: Count leading zeros gives 0 for a set top bit and 32 for a zero operand.
// RULE14: The constant load writes the zero-extended 16-bit constant to bits 15..8 register.
// RULE15: The high constant load replaces the upper half and keeps the lower half.
// RULE16: The negative constant load writes the constant with ones in the upper half.
// RULE17: Assertions use opcode 31..24, vector 23..16, first reg 15..8, second 7..0.
`timescale 1ns/1ps
`include "acce_consts.svh"
module acce_exec
  import acce_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic issue_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] pc_i,
  input wire logic user_mode_i,
  input wire logic [31:0] first_source_i,
  input wire logic [31:0] reg_b_i,
  input wire logic [31:0] class_hi_i,
  input wire logic [31:0] class_lo_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic irq_o,
  output logic wr_en_o,
  output logic [7:0] wr_reg_o,
  output logic [31:0] wr_data_o,
  output logic branch_o,
  output logic [31:0] target_o,
  output logic trap_o,
  output logic [7:0] trap_vec_o,
  output logic prot_trap_o,
  output logic class_trap_o,
  output logic [7:0] indirect_pointer_a_o,
  output logic [7:0] indirect_pointer_b_o,
  output logic [7:0] indirect_pointer_c_o,
  output logic [31:0] class_result_o
);

  // Counts zero bits above the first one; 32 for a zero word.
  function automatic logic [5:0] clz32(input logic [31:0] v);
    logic [5:0] n;
    logic hit;
    n = 6'h20;
    hit = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!hit && v[i]) begin
        n = 6'(31 - i);
        hit = 1'b1;
      end
    end
    return n;
  endfunction : clz32

  // Classifies an operand; bits 51..0 of frac hold the fraction left-aligned.
  function automatic logic [31:0] classify(input logic sign, input logic [10:0] bexp,
                                           input logic [10:0] maxe, input logic [51:0] frac,
                                           input logic [51:0] ones);
    logic [1:0] fc;
    logic [2:0] ec;
    logic [4:0] efc;
    fc = (frac == 52'h0) ? 2'h0 : ((frac == ones) ? 2'h3 : 2'h2);
    if (bexp == 11'h000) begin
      ec = 3'h0;
    end else if (bexp == 11'h001) begin
      ec = 3'h1;
    end else if (bexp < maxe) begin
      ec = 3'h2;
    end else if (bexp == maxe) begin
      ec = 3'h3;
    end else begin
      ec = 3'h4;
    end
    if (ec == 3'h4) begin
      if (frac == 52'h0) begin
        efc = `ACCE_EFC_INF; // [RULE11]
      end else begin
        efc = frac[51] ? `ACCE_EFC_QUIET_NAN : `ACCE_EFC_SIGNALLING_NAN; // [RULE11]
      end
    end else if (ec == 3'h0 && fc == 2'h0) begin
      efc = `ACCE_EFC_ZERO; // [RULE11]
    end else begin
      efc = {ec[1:0], 1'b0, fc};
    end
    return {26'h0, sign, efc}; // [RULE10]
  endfunction : classify

  // Field decode shared by all instructions.
  logic [7:0] opc;
  logic [7:0] vector_field;
  logic [7:0] first_reg_field;
  logic [7:0] second_reg_field;
  logic [1:0] source_format_field;
  logic [15:0] imm16;
  logic [31:0] second_source;
  assign opc = {instr_i[31:25], 1'b0};
  assign vector_field = instr_i[23:16]; // [RULE17]
  assign first_reg_field = instr_i[15:8]; // [RULE17]
  assign second_reg_field = instr_i[7:0]; // [RULE17]
  assign source_format_field = instr_i[1:0];
  assign imm16 = {instr_i[23:16], instr_i[7:0]};
  assign second_source = instr_i[24] ? {24'h0, second_reg_field} : reg_b_i; // [RULE4]

  // Assertion outcome; a false assertion traps, unless the vector is protected.
  logic is_assert;
  logic holds;
  always_comb begin
    is_assert = 1'b1;
    holds = 1'b1;
    unique case (opc)
      `ACCE_OP_GT: holds = $signed(first_source_i) > $signed(second_source); // [RULE1]
      `ACCE_OP_LE: holds = $signed(first_source_i) <= $signed(second_source); // [RULE1]
      `ACCE_OP_LT: holds = $signed(first_source_i) < $signed(second_source); // [RULE1]
      `ACCE_OP_GTU: holds = first_source_i > second_source; // [RULE2]
      `ACCE_OP_LEU: holds = first_source_i <= second_source; // [RULE2]
      `ACCE_OP_LTU: holds = first_source_i < second_source; // [RULE2]
      `ACCE_OP_NE: holds = first_source_i != second_source; // [RULE3]
      default: is_assert = 1'b0;
    endcase
  end

  acce_trap_t next_trap;
  always_comb begin
    if (!issue_i || !is_assert || holds) begin
      next_trap = ACCE_TRAP_NONE;
    end else if (user_mode_i && vector_field <= `ACCE_USER_VEC_MAX) begin
      next_trap = ACCE_TRAP_PROT; // [RULE5]
    end else begin
      next_trap = ACCE_TRAP_VEC;
    end
  end

  logic is_class;
  logic fmt_ok;
  logic is_known;
  assign is_class = issue_i && instr_i[31:24] == `ACCE_OP_CLASS;
  assign fmt_ok = source_format_field == `ACCE_FMT_SINGLE ||
                  source_format_field == `ACCE_FMT_DOUBLE; // [RULE12]
  assign is_known = is_assert || opc == `ACCE_OP_CALL || instr_i[31:24] == `ACCE_OP_INDIRECT_CALL ||
                    opc == `ACCE_OP_CLZ || instr_i[31:24] == `ACCE_OP_CONST ||
                    instr_i[31:24] == `ACCE_OP_HIGH_CONSTANT_LOAD || instr_i[31:24] == `ACCE_OP_NEGATIVE_CONSTANT_LOAD ||
                    instr_i[31:24] == `ACCE_OP_CLASS;

  // Trap outputs, registered one cycle after issue.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_o <= 1'b0;
      prot_trap_o <= 1'b0;
      trap_vec_o <= 8'h00;
      class_trap_o <= 1'b0;
      indirect_pointer_a_o <= 8'h00;
      indirect_pointer_b_o <= 8'h00;
      indirect_pointer_c_o <= 8'h00;
    end else begin
      trap_o <= next_trap == ACCE_TRAP_VEC; // [RULE1] [RULE2] [RULE3]
      prot_trap_o <= next_trap == ACCE_TRAP_PROT; // [RULE5]
      trap_vec_o <= (next_trap == ACCE_TRAP_VEC) ? vector_field : 8'h00;
      class_trap_o <= is_class; // [RULE9]
      if (is_class) begin
        indirect_pointer_a_o <= first_reg_field; // [RULE9]
        indirect_pointer_c_o <= vector_field; // [RULE9]
        indirect_pointer_b_o <= {6'h00, source_format_field}; // [RULE9]
      end
    end
  end

  // Classification result, offered to the emulation handler.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      class_result_o <= 32'h0;
    end else if (is_class && source_format_field == `ACCE_FMT_SINGLE) begin
      class_result_o <= classify(class_hi_i[31], {3'h0, class_hi_i[30:23]}, `ACCE_MAX_SP,
                                 {class_hi_i[22:0], 29'h0}, {23'h7FFFFF, 29'h0}); // [RULE12]
    end else if (is_class && source_format_field == `ACCE_FMT_DOUBLE) begin
      class_result_o <= classify(class_hi_i[31], class_hi_i[30:20], `ACCE_MAX_DP,
                                 {class_hi_i[19:0], class_lo_i}, 52'hF_FFFF_FFFF_FFFF);
    end
  end

  // Register write-back for calls, clz and the constant loads.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_en_o <= 1'b0;
      wr_reg_o <= 8'h00;
      wr_data_o <= 32'h0;
    end else begin
      wr_en_o <= 1'b0;
      if (issue_i) begin
        if (opc == `ACCE_OP_CALL || instr_i[31:24] == `ACCE_OP_INDIRECT_CALL) begin
          wr_en_o <= 1'b1;
          wr_reg_o <= first_reg_field;
          wr_data_o <= pc_i + `ACCE_LINK_OFS; // [RULE6] [RULE8]
        end else if (opc == `ACCE_OP_CLZ) begin
          wr_en_o <= 1'b1;
          wr_reg_o <= vector_field;
          wr_data_o <= {26'h0, clz32(second_source)}; // [RULE13]
        end else if (instr_i[31:24] == `ACCE_OP_CONST) begin
          wr_en_o <= 1'b1;
          wr_reg_o <= first_reg_field;
          wr_data_o <= {16'h0000, imm16}; // [RULE14]
        end else if (instr_i[31:24] == `ACCE_OP_HIGH_CONSTANT_LOAD) begin
          wr_en_o <= 1'b1;
          wr_reg_o <= first_reg_field;
          wr_data_o <= {imm16, first_source_i[15:0]}; // [RULE15]
        end else if (instr_i[31:24] == `ACCE_OP_NEGATIVE_CONSTANT_LOAD) begin
          wr_en_o <= 1'b1;
          wr_reg_o <= first_reg_field;
          wr_data_o <= {16'hFFFF, imm16}; // [RULE16]
        end
      end
    end
  end

  // Branch request; the fetch unit runs the delay slot before the target.
  logic [31:0] word_ofs;
  assign word_ofs = {{14{imm16[15]}}, imm16, 2'b00};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      branch_o <= 1'b0;
      target_o <= 32'h0;
    end else begin
      branch_o <= 1'b0;
      if (issue_i && opc == `ACCE_OP_CALL) begin
        branch_o <= 1'b1; // [RULE6]
        target_o <= instr_i[24] ? word_ofs : pc_i + word_ofs; // [RULE7]
      end else if (issue_i && instr_i[31:24] == `ACCE_OP_INDIRECT_CALL) begin
        branch_o <= 1'b1;
        target_o <= reg_b_i; // [RULE8]
      end
    end
  end

  // Sticky event status, cleared by a status read; a new event wins over the clear.
  logic [3:0] status;
  logic [3:0] mask;
  logic [3:0] events;
  logic [3:0] last_op;
  logic rd_status;
  assign events[`ACCE_EV_ASSERT] = next_trap == ACCE_TRAP_VEC;
  assign events[`ACCE_EV_PROT] = next_trap == ACCE_TRAP_PROT;
  assign events[`ACCE_EV_CLASS] = is_class;
  assign events[`ACCE_EV_ILLEGAL] = (issue_i && !is_known) || (is_class && !fmt_ok);
  assign rd_status = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
                     wb_adr_i == `ACCE_REG_STATUS;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= 4'h0;
    end else begin
      status <= (rd_status ? 4'h0 : status) | events;
    end
  end
  assign irq_o = |(status & mask);

  // Low four bits (27..24) of the last issued opcode, visible to software for diagnosis.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_op <= 4'h0;
    end else if (issue_i) begin
      last_op <= instr_i[27:24];
    end
  end

  // Wishbone slave: one-cycle ack, error on an unmapped address.
  logic req;
  logic mapped;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = wb_adr_i == `ACCE_REG_STATUS || wb_adr_i == `ACCE_REG_MASK ||
                  wb_adr_i == `ACCE_REG_CTRL || wb_adr_i == `ACCE_REG_LAST;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
      mask <= 4'h0;
    end else begin
      wb_ack_o <= req && mapped;
      wb_err_o <= req && !mapped;
      if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == `ACCE_REG_MASK) begin
        mask <= wb_dat_i[3:0];
      end
      if (req && !wb_we_i) begin
        unique case (wb_adr_i)
          `ACCE_REG_STATUS: wb_dat_o <= {28'h0, status};
          `ACCE_REG_MASK: wb_dat_o <= {28'h0, mask};
          `ACCE_REG_LAST: wb_dat_o <= {28'h0, last_op};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // Checks next to the logic they guard.
  property p_vec_trap;
    @(posedge clk_i) disable iff (rst_i)
      issue_i && is_assert && !holds && !(user_mode_i && vector_field <= 8'h3F)
      |=> trap_o && trap_vec_o == $past(vector_field);
  endproperty
  a_vec_trap: assert property (p_vec_trap) else $error("assert trap missing"); // [RULE1]

  property p_holds_no_trap;
    @(posedge clk_i) disable iff (rst_i) issue_i && is_assert && holds |=> !trap_o && !prot_trap_o;
  endproperty
  a_holds_no_trap: assert property (p_holds_no_trap) else $error("spurious trap"); // [RULE2]

  property p_ne;
    @(posedge clk_i) disable iff (rst_i)
      issue_i && opc == 8'h72 && first_source_i == second_source && !user_mode_i |=> trap_o;
  endproperty
  a_ne: assert property (p_ne) else $error("not-equal trap missing"); // [RULE3]

  // An immediate equal to the first operand must pass an unsigned less-or-equal check.
  // A mux that picked the register in place of the byte would trap here.
  property p_imm;
    @(posedge clk_i) disable iff (rst_i)
      issue_i && instr_i[24] && {instr_i[31:25], 1'b0} == `ACCE_OP_LEU &&
      first_source_i <= {24'h0, instr_i[7:0]} |=> !trap_o && !prot_trap_o;
  endproperty
  a_imm: assert property (p_imm) else $error("immediate not zero-extended"); // [RULE4]

  property p_prot;
    @(posedge clk_i) disable iff (rst_i)
      issue_i && is_assert && !holds && user_mode_i && vector_field < 8'h40
      |=> prot_trap_o && !trap_o;
  endproperty
  a_prot: assert property (p_prot) else $error("protection trap missing"); // [RULE5]

  property p_link;
    @(posedge clk_i) disable iff (rst_i)
      issue_i && (opc == 8'hA8 || instr_i[31:24] == 8'hC8)
      |=> wr_en_o && branch_o && wr_data_o == $past(pc_i) + 32'h8;
  endproperty
  a_link: assert property (p_link) else $error("call link wrong"); // [RULE6]

  property p_clz;
    @(posedge clk_i) disable iff (rst_i)
      issue_i && opc == 8'h08 && second_source == 32'h0 |=> wr_data_o == 32'h20;
  endproperty
  a_clz: assert property (p_clz) else $error("clz of zero wrong"); // [RULE13]

  property p_negative_constant_load;
    @(posedge clk_i) disable iff (rst_i)
      issue_i && instr_i[31:24] == 8'h01 |=> wr_data_o[31:16] == 16'hFFFF && wr_en_o;
  endproperty
  a_negative_constant_load: assert property (p_negative_constant_load) else $error("ones extension wrong"); // [RULE16]

  property p_class;
    @(posedge clk_i) disable iff (rst_i)
      is_class |=> class_trap_o && indirect_pointer_b_o == {6'h0, $past(instr_i[1:0])}
      && class_result_o[31:6] == 26'h0;
  endproperty
  a_class: assert property (p_class) else $error("classify trap wrong"); // [RULE9]

endmodule : acce_exec

// [common/acce_consts.svh]
// Constants for the assert, call, constant and classify execution slice.
`ifndef ACCE_CONSTS_SVH
`define ACCE_CONSTS_SVH
`define ACCE_OP_GT 8'h58
`define ACCE_OP_GTU 8'h5A
`define ACCE_OP_LE 8'h54
`define ACCE_OP_LEU 8'h56
`define ACCE_OP_LT 8'h50
`define ACCE_OP_LTU 8'h52
`define ACCE_OP_NE 8'h72
`define ACCE_OP_CALL 8'hA8
`define ACCE_OP_INDIRECT_CALL 8'hC8
`define ACCE_OP_CLZ 8'h08
`define ACCE_OP_CONST 8'h03
`define ACCE_OP_HIGH_CONSTANT_LOAD 8'h02
`define ACCE_OP_NEGATIVE_CONSTANT_LOAD 8'h01
`define ACCE_OP_CLASS 8'hE6
`define ACCE_LINK_OFS 32'h0000_0008
`define ACCE_USER_VEC_MAX 8'h3F
`define ACCE_FMT_SINGLE 2'h1
`define ACCE_FMT_DOUBLE 2'h2
`define ACCE_EFC_ZERO 5'h00
`define ACCE_EFC_INF 5'h10
`define ACCE_EFC_SIGNALLING_NAN 5'h12
`define ACCE_EFC_QUIET_NAN 5'h13
`define ACCE_MAX_SP 11'h0FE
`define ACCE_MAX_DP 11'h7FE
`define ACCE_REG_STATUS 32'h0000_0000
`define ACCE_REG_MASK 32'h0000_0004
`define ACCE_REG_CTRL 32'h0000_0008
`define ACCE_REG_LAST 32'h0000_000C
`define ACCE_EV_ASSERT 0
`define ACCE_EV_PROT 1
`define ACCE_EV_CLASS 2
`define ACCE_EV_ILLEGAL 3
`endif

// [common/acce_pkg.sv]
// Types shared by the execution slice.
package acce_pkg;
  typedef enum logic [2:0] {
    ACCE_TRAP_NONE = 3'b001,
    ACCE_TRAP_VEC = 3'b010,
    ACCE_TRAP_PROT = 3'b100
  } acce_trap_t;
endpackage : acce_pkg

// [verif/test_acce_exec.sv]
// Self-checking bench for the assert, call, constant and classify slice.
`timescale 1ns/1ps
`include "acce_consts.svh"
module test_acce_exec;
  import acce_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, issue_i = 1'b0, user_mode_i = 1'b0;
  logic [31:0] instr_i = '0, pc_i = '0, first_source_i = '0, reg_b_i = '0;
  logic [31:0] class_hi_i = '0, class_lo_i = '0, wb_adr_i = '0, wb_dat_i = '0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o, wr_data_o, target_o, class_result_o;
  logic wb_ack_o, wb_err_o, irq_o, wr_en_o, branch_o, trap_o, prot_trap_o, class_trap_o;
  logic [7:0] wr_reg_o, trap_vec_o, indirect_pointer_a_o, indirect_pointer_b_o;
  logic [7:0] indirect_pointer_c_o;
  int err_total = 0;
  int n_tests = 0;
  // Operands staged by the sequence and launched by the issue task.
  logic [31:0] op_a, op_b, op_pc, op_h, op_l, q;
  logic op_u, e;
  // Expected sticky status and the mask last written.
  logic [3:0] st = 4'h0, msk = 4'h0;

  acce_exec DUT (.clk_i, .rst_i, .issue_i, .instr_i, .pc_i, .user_mode_i, .first_source_i,
    .reg_b_i, .class_hi_i, .class_lo_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
    .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o, .irq_o, .wr_en_o, .wr_reg_o,
    .wr_data_o, .branch_o, .target_o, .trap_o, .trap_vec_o, .prot_trap_o, .class_trap_o,
    .indirect_pointer_a_o, .indirect_pointer_b_o, .indirect_pointer_c_o, .class_result_o);

  // Free-running core clock, 10 ns period.
  always #5 clk_i = ~clk_i;

  task automatic stop_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      $display("ERROR %s expected %h seen %h", n, x, g);
      err_total++;
    end
  endtask : check

  // One instruction: launched on one edge, results read just after the next.
  task automatic exec(input logic [31:0] i);
    @(posedge clk_i);
    issue_i <= 1'b1;
    instr_i <= i;
    first_source_i <= op_a;
    reg_b_i <= op_b;
    pc_i <= op_pc;
    user_mode_i <= op_u;
    class_hi_i <= op_h;
    class_lo_i <= op_l;
    @(posedge clk_i);
    issue_i <= 1'b0;
    #1;
  endtask : exec

  // Pulse outputs in order wr_en, branch, trap, prot, class; irq from the model.
  task automatic pulses(input logic [4:0] x);
    check("pulses", {26'h0, x, |(st & msk)},
      {26'h0, wr_en_o, branch_o, trap_o, prot_trap_o, class_trap_o, irq_o});
  endtask : pulses

  // Classic single cycle; the wait is bounded so a dead slave cannot hang the run.
  task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
    end
    if (k == 20) begin
      err_total++;
      stop_test();
    end
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    #1;
  endtask : wb

  task automatic rd_status();
    wb(`ACCE_REG_STATUS, 1'b0, 32'h0);
    check("status", {28'h0, st}, q);
    st = 4'h0;
  endtask : rd_status

  initial begin
    logic [31:0] sb, t, off;
    logic [7:0] imm, vec, r;
    logic ok, pv, m;
    static logic [7:0] aops [7] = '{`ACCE_OP_GT, `ACCE_OP_GTU, `ACCE_OP_LE, `ACCE_OP_LEU,
      `ACCE_OP_LT, `ACCE_OP_LTU, `ACCE_OP_NE};
    static logic [7:0] cops [3] = '{`ACCE_OP_CONST, `ACCE_OP_HIGH_CONSTANT_LOAD, `ACCE_OP_NEGATIVE_CONSTANT_LOAD};
    static logic [1:0] cf [10] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
    static logic [31:0] ch [10] = '{32'h0, 32'h8000_0000, 32'h7F80_0000, 32'h7F80_0001,
      32'h7FC0_0000, 32'hFF80_0000, 32'h7FF0_0000, 32'h7FF8_0000, 32'h7FF0_0000,
      32'h8000_0000};
    static logic [5:0] ce [10] = '{6'h00, 6'h20, 6'h10, 6'h12, 6'h13, 6'h30, 6'h10, 6'h13,
      6'h12, 6'h20};
    void'($urandom(64));
    {op_a, op_b, op_pc, op_h, op_l, op_u} = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    pulses(5'h00);
    rd_status();
    wb(`ACCE_REG_MASK, 1'b1, 32'hFFFF_FFFF);
    wb(`ACCE_REG_MASK, 1'b0, 32'h0);
    check("mask", 32'hF, q);
    wb(`ACCE_REG_MASK, 1'b1, 32'h0);
    wb(`ACCE_REG_CTRL, 1'b0, 32'h0);
    check("ctrl", 32'h0, q);
    wb(32'h0000_0010, 1'b0, 32'h0);
    check("unmapped err", 32'h1, {31'h0, e});
    // Every assertion kind, both operand sources, both modes, low and high vectors.
    for (int k = 0; k < 70; k++) begin
      m = 1'($urandom % 2);
      op_a = $urandom;
      op_b = ($urandom % 3 == 0) ? op_a : $urandom;
      imm = 8'($urandom);
      if (m && ($urandom % 2 == 0)) op_a = {24'h0, imm};
      sb = m ? {24'h0, imm} : op_b;
      vec = ($urandom % 2 == 0) ? 8'($urandom % 64) : 8'($urandom);
      op_u = 1'($urandom % 2);
      case (k % 7)
        0: ok = $signed(op_a) > $signed(sb);
        1: ok = op_a > sb;
        2: ok = $signed(op_a) <= $signed(sb);
        3: ok = op_a <= sb;
        4: ok = $signed(op_a) < $signed(sb);
        5: ok = op_a < sb;
        default: ok = op_a != sb;
      endcase
      pv = !ok && op_u && (vec <= `ACCE_USER_VEC_MAX);
      st = st | {2'b00, pv, !ok && !pv};
      exec({aops[k % 7] | {7'h0, m}, vec, 8'($urandom), imm});
      pulses({2'b00, !ok && !pv, pv, 1'b0});
      check("vector", {24'h0, (!ok && !pv) ? vec : 8'h00}, {24'h0, trap_vec_o});
      if (k == 13) begin
        wb(`ACCE_REG_MASK, 1'b1, 32'hF);
        msk = 4'hF;
        check("irq", {31'h0, |st}, {31'h0, irq_o});
      end
      if (k == 40) rd_status();
    end
    rd_status();
    op_u = 1'b0;
    // Leading zeros over zero, top bit set and shifted random values.
    for (int k = 0; k < 8; k++) begin
      op_b = (k == 0) ? 32'h0 : (k == 1) ? 32'h8000_0000 : $urandom >> ($urandom % 32);
      m = (k > 1) && k[0];
      imm = 8'($urandom);
      sb = m ? {24'h0, imm} : op_b;
      t = 32'd32;
      for (int j = 31; j >= 0; j--) begin
        if (sb[j]) begin
          t = 32'(31 - j);
          break;
        end
      end
      r = 8'($urandom);
      exec({`ACCE_OP_CLZ | {7'h0, m}, r, 8'h00, imm});
      pulses(5'h10);
      check("clz reg", {24'h0, r}, {24'h0, wr_reg_o});
      check("clz", t, wr_data_o);
    end
    // The three 16-bit constant loads.
    for (int k = 0; k < 3; k++) begin
      op_a = $urandom;
      {vec, r, imm} = 24'($urandom);
      exec({cops[k], vec, r, imm});
      t = (k == 0) ? {16'h0, vec, imm} : (k == 1) ? {vec, imm, op_a[15:0]} : {16'hFFFF, vec, imm};
      pulses(5'h10);
      check("const reg", {24'h0, r}, {24'h0, wr_reg_o});
      check("const", t, wr_data_o);
    end
    // Relative, absolute and indirect calls, all linking past the delay slot.
    for (int k = 0; k < 6; k++) begin
      op_pc = $urandom & 32'hFFFF_FFFC;
      op_b = $urandom;
      {vec, r, imm} = 24'($urandom);
      off = {{14{vec[7]}}, vec, imm, 2'b00};
      t = k[1] ? op_b : k[0] ? off : op_pc + off;
      exec(k[1] ? {`ACCE_OP_INDIRECT_CALL, 8'h00, r, imm} : {`ACCE_OP_CALL | {7'h0, k[0]}, vec, r, imm});
      pulses(5'h18);
      check("link reg", {24'h0, r}, {24'h0, wr_reg_o});
      check("link", op_pc + `ACCE_LINK_OFS, wr_data_o);
      check("target", t, target_o);
    end
    // Classify traps with the pointers set and the class code ready.
    for (int k = 0; k < 10; k++) begin
      op_h = ch[k];
      op_l = (k == 8) ? 32'h1 : 32'h0;
      {vec, r} = 16'($urandom);
      st = st | 4'h4;
      exec({`ACCE_OP_CLASS, vec, r, 6'h00, cf[k]});
      pulses(5'h01);
      check("ptr a", {24'h0, r}, {24'h0, indirect_pointer_a_o});
      check("ptr b", {30'h0, cf[k]}, {24'h0, indirect_pointer_b_o});
      check("ptr c", {24'h0, vec}, {24'h0, indirect_pointer_c_o});
      check("class", {26'h0, ce[k]}, class_result_o);
    end
    // A reserved format still traps to the handler but also flags the illegal status bit.
    st = st | 4'hC;
    exec({`ACCE_OP_CLASS, 8'h11, 8'h22, 8'h00});
    pulses(5'h01);
    check("ptr a reserved", 32'h22, {24'h0, indirect_pointer_a_o});
    check("ptr b reserved", 32'h0, {24'h0, indirect_pointer_b_o});
    rd_status();
    // An opcode outside the slice only flags the illegal status bit.
    st = 4'h8;
    exec(32'hFF00_0000);
    pulses(5'h00);
    wb(`ACCE_REG_LAST, 1'b0, 32'h0);
    check("last", 32'hF, q);
    rd_status();
    pulses(5'h00);
    // A second reset in mid-run clears the sticky status, the mask and every pulse.
    st = 4'h8;
    exec(32'hFF00_0000);
    pulses(5'h00);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    {st, msk} = 8'h00;
    @(posedge clk_i);
    #1;
    pulses(5'h00);
    wb(`ACCE_REG_MASK, 1'b0, 32'h0);
    check("mask after reset", 32'h0, q);
    rd_status();
    stop_test();
  end
endmodule : test_acce_exec
